// ---- hdl/sxe_exec.sv ----
// Execution of skip-if-zero, xor literal and extended-set classification
// Behaviour
// - skip-if-zero on zero discards the next fetch, runs two cycles
// - access bit zero selects access bank, one uses bank select register
// - extended set, access zero, operand up to 95 uses indexed offset
// - xor literal combines working register with 8-bit literal, one cycle
// - xor literal writes working register, updates only negative and zero
// - extended features off after reset until config bit set
// - extended set adds eight opcodes plus indexed offset addressing
// - extended ops except call and moves are pointer literal operations
// - third-pointer add and subtract variants return automatically
`timescale 1ns/1ns
`include "sxe_cfg.svh"
module sxe_exec
	import sxe_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Instruction and configuration
	input  wire logic [15:0] instr,
	input  wire logic       instr_valid,
	input  wire logic       extended_set_config_bit,
	input  wire logic [3:0] bank_select_register,
	input  wire logic [7:0] file_data,
	// Register file access
	output logic            file_rd,
	output logic [11:0]     file_addr,
	output logic            indexed_mode,
	// Working register and flags
	output logic [7:0]      working,
	output logic            flag_n,
	output logic            flag_z,
	output logic            flag_we,
	// Sequencing
	output logic            skip_active,
	output logic            quarter_q1,
	// Extended classification
	output sxe_ext_t        ext_kind_q,
	output logic            ptr_literal_q,
	output logic            auto_return_q,
	output logic            ext_enabled
);
	// Quarter-cycle sequence and skip state
	sxe_q_t      q, next_q;
	logic        skip_pend, next_skip_pend;
	logic        skip_active_r, next_skip_active;
	logic        ext_en, next_ext_en;
	logic [7:0]  w, next_w;
	logic        n_r, next_n;
	logic        z_r, next_z;
	logic        fwe, next_fwe;
	logic        frd, next_frd;
	logic [11:0] fa, next_fa;
	logic        idx, next_idx;
	sxe_ext_t    kind_c, kind_r, next_kind;
	logic        ptr_c, ptr_r, next_ptr;
	logic        ret_c, ret_r, next_ret;
	logic        is_tst, is_xor;
	logic [7:0]  xor_res;

	sxe_ext_decode u_dec (
		.instr          (instr),
		.ext_en         (ext_en),
		.ext_kind       (kind_c),
		.ptr_literal_op (ptr_c),
		.auto_return    (ret_c)
	);

	// Opcode matches
	assign is_tst  = (instr[15:9] == `SXE_OP_TSTZ_HI);
	assign is_xor  = (instr[15:8] == `SXE_OP_XORL_HI);
	assign xor_res = w ^ instr[7:0];

	// Next-state computation
	always_comb begin
		next_q           = q;
		next_skip_pend   = skip_pend;
		next_skip_active = skip_active_r;
		next_ext_en      = ext_en;
		next_w           = w;
		next_n           = n_r;
		next_z           = z_r;
		next_fwe         = 1'b0;
		next_frd         = 1'b0;
		next_fa          = fa;
		next_idx         = idx;
		next_kind        = kind_r;
		next_ptr         = ptr_r;
		next_ret         = ret_r;
		case (q)
			SXE_Q1: begin
				next_q = SXE_Q2;
				// sample config at each cycle start
				next_ext_en = extended_set_config_bit;
				// a pending skip turns this cycle into a no-op
				next_skip_active = skip_pend;
				next_skip_pend   = 1'b0;
			end
			SXE_Q2: begin
				next_q = SXE_Q3;
				// no read during a discarded cycle
				if (!skip_active_r && instr_valid) begin
					next_kind = kind_c;
					next_ptr  = ptr_c;
					next_ret  = ret_c;
					if (is_tst) begin
						next_frd = 1'b1;
						if (ext_en && !instr[`SXE_ACC_BIT] && instr[7:0] <= `SXE_IDX_LIMIT) begin
							next_idx = 1'b1;
							next_fa  = {4'h0, instr[7:0]};
						end else begin
							next_idx = 1'b0;
							// access bank or banked general purpose
							if (!instr[`SXE_ACC_BIT]) begin
								next_fa = {{4{instr[7]}}, instr[7:0]};
							end else begin
								next_fa = {bank_select_register, instr[7:0]};
							end
						end
					end
				end else begin
					next_kind = SXE_EXT_NONE;
					next_ptr  = 1'b0;
					next_ret  = 1'b0;
				end
			end
			SXE_Q3: begin
				next_q = SXE_Q4;
				if (!skip_active_r && instr_valid && is_tst && file_data == 8'h00) begin
					next_skip_pend = 1'b1;
				end
			end
			SXE_Q4: begin
				next_q = SXE_Q1;
				// write working register and only N, Z
				if (!skip_active_r && instr_valid && is_xor) begin
					next_w   = xor_res;
					next_z   = (xor_res == 8'h00);
					next_n   = xor_res[`SXE_NEG_BIT];
					next_fwe = 1'b1;
				end
			end
			default: begin
				next_q = SXE_Q1;
			end
		endcase
	end

	// State registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			q             <= SXE_Q1;
			skip_pend     <= 1'b0;
			skip_active_r <= 1'b0;
			ext_en        <= 1'b0;
			w             <= `SXE_RST_W;
			n_r           <= 1'b0;
			z_r           <= 1'b0;
			fwe           <= 1'b0;
			frd           <= 1'b0;
			fa            <= 12'h000;
			idx           <= 1'b0;
			kind_r        <= SXE_EXT_NONE;
			ptr_r         <= 1'b0;
			ret_r         <= 1'b0;
		end else begin
			q             <= next_q;
			skip_pend     <= next_skip_pend;
			skip_active_r <= next_skip_active;
			ext_en        <= next_ext_en;
			w             <= next_w;
			n_r           <= next_n;
			z_r           <= next_z;
			fwe           <= next_fwe;
			frd           <= next_frd;
			fa            <= next_fa;
			idx           <= next_idx;
			kind_r        <= next_kind;
			ptr_r         <= next_ptr;
			ret_r         <= next_ret;
		end
	end

	// Outputs straight from flops
	assign file_rd       = frd;
	assign file_addr     = fa;
	assign indexed_mode  = idx;
	assign working       = w;
	assign flag_n        = n_r;
	assign flag_z        = z_r;
	assign flag_we       = fwe;
	assign skip_active   = skip_active_r;
	assign quarter_q1    = q[0]; // One-hot Q1 bit, no gate after the flop
	assign ext_kind_q    = kind_r;
	assign ptr_literal_q = ptr_r;
	assign auto_return_q = ret_r;
	assign ext_enabled   = ext_en;

	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_zero_test;
		q == SXE_Q3 && !skip_active_r && instr_valid && is_tst && file_data == 8'h00;
	endsequence
	sequence s_dead_cycle;
		skip_active_r [*4];
	endsequence

	// Armed in Q3, dead cycle starts one clock after the following Q1
	a_skip_arms_nop: assert property (s_zero_test |-> ##3 s_dead_cycle)
		else $error("zero test did not produce a discarded cycle");
	a_skip_no_effect: assert property (skip_active_r |-> ##1 (!fwe && !frd))
		else $error("discarded cycle had an effect");
	a_bank_select: assert property (q == SXE_Q2 && !skip_active_r && instr_valid && is_tst
		&& instr[`SXE_ACC_BIT] |=> fa[11:8] == $past(bank_select_register))
		else $error("banked address wrong");
	a_index_mode: assert property (q == SXE_Q2 && !skip_active_r && instr_valid && is_tst
		&& ext_en && !instr[`SXE_ACC_BIT] && instr[7:0] <= 8'h5F |=> idx)
		else $error("indexed offset mode not used");
	a_xor_result: assert property (q == SXE_Q4 && !skip_active_r && instr_valid && is_xor
		|=> w == ($past(w) ^ $past(instr[7:0])))
		else $error("xor result wrong");
	a_xor_flags: assert property (fwe |-> (z_r == (w == 8'h00)) && (n_r == w[7]))
		else $error("flags mismatch result");
	a_w_stable: assert property (!$past(is_xor) |-> $stable(w))
		else $error("working register changed outside xor");
	a_ext_off: assert property (!ext_en && q == SXE_Q2
		|=> kind_r == SXE_EXT_NONE && !ptr_r && !ret_r)
		else $error("extended op decoded while disabled");
	a_auto_return: assert property (ret_r |-> ptr_r)
		else $error("return variant not a pointer literal");
	a_ptr_class: assert property (kind_r == SXE_EXT_CALL_VIA_WORKING_REGISTER |-> !ptr_r)
		else $error("call misclassified");
endmodule

// ---- hdl/sxe_cfg.svh ----
// Constants for the skip, xor and extended-set execution block
`ifndef SXE_CFG_SVH
`define SXE_CFG_SVH
`define SXE_OP_TSTZ_HI      7'h33
`define SXE_OP_XORL_HI      8'h0A
`define SXE_OP_ADDP_HI      8'hE8
`define SXE_OP_SUBP_HI      8'hE9
`define SXE_OP_PUSHL_HI     8'hEA
`define SXE_OP_MOVS_HI      8'hEB
`define SXE_OP_CALL_VIA_WORKING_REGISTER        16'h0014
`define SXE_IDX_LIMIT       8'h5F
`define SXE_PTR_THIRD       2'h3
`define SXE_STD_COUNT       8'h4B
`define SXE_EXT_COUNT       4'h8
`define SXE_ACC_BIT         8
`define SXE_NEG_BIT         7
`define SXE_RST_W           8'h00
`define SXE_RST_Q           4'h1
`endif

// ---- hdl/sxe_pkg.sv ----
// Types for the skip, xor and extended-set execution block
package sxe_pkg;
	typedef enum logic [3:0] {
		SXE_Q1 = 4'h1,
		SXE_Q2 = 4'h2,
		SXE_Q3 = 4'h4,
		SXE_Q4 = 4'h8
	} sxe_q_t;
	typedef enum logic [3:0] {
		SXE_EXT_NONE  = 4'h0,
		SXE_EXT_ADDP  = 4'h1,
		SXE_EXT_SUBP  = 4'h2,
		SXE_EXT_ADDR  = 4'h3,
		SXE_EXT_SUBR  = 4'h4,
		SXE_EXT_PUSHL = 4'h5,
		SXE_EXT_CALL_VIA_WORKING_REGISTER = 4'h6,
		SXE_EXT_MVSF  = 4'h7,
		SXE_EXT_MVSS  = 4'h8
	} sxe_ext_t;
endpackage

// ---- hdl/sxe_ext_decode.sv ----
// Extended instruction classifier
`timescale 1ns/1ns
`include "sxe_cfg.svh"
module sxe_ext_decode
	import sxe_pkg::*;
(
	// Instruction word and enable
	input  wire logic [15:0] instr,
	input  wire logic        ext_en,
	// Classification
	output sxe_ext_t         ext_kind,
	output logic             ptr_literal_op,
	output logic             auto_return
);
	// Decode only when the extended set is enabled
	always_comb begin
		ext_kind       = SXE_EXT_NONE;
		ptr_literal_op = 1'b0;
		auto_return    = 1'b0;
		if (ext_en) begin
			case (instr[15:8])
				`SXE_OP_ADDP_HI: begin
					ext_kind = (instr[7:6] == `SXE_PTR_THIRD) ? SXE_EXT_ADDR : SXE_EXT_ADDP;
				end
				`SXE_OP_SUBP_HI: begin
					ext_kind = (instr[7:6] == `SXE_PTR_THIRD) ? SXE_EXT_SUBR : SXE_EXT_SUBP;
				end
				`SXE_OP_PUSHL_HI: begin
					ext_kind = SXE_EXT_PUSHL;
				end
				`SXE_OP_MOVS_HI: begin
					ext_kind = instr[7] ? SXE_EXT_MVSS : SXE_EXT_MVSF;
				end
				default: begin
					ext_kind = (instr == `SXE_OP_CALL_VIA_WORKING_REGISTER) ? SXE_EXT_CALL_VIA_WORKING_REGISTER : SXE_EXT_NONE;
				end
			endcase
			// all but call and moves are pointer literals
			ptr_literal_op = (ext_kind != SXE_EXT_NONE) && (ext_kind != SXE_EXT_CALL_VIA_WORKING_REGISTER)
				&& (ext_kind != SXE_EXT_MVSF) && (ext_kind != SXE_EXT_MVSS);
			auto_return = (ext_kind == SXE_EXT_ADDR) || (ext_kind == SXE_EXT_SUBR);
		end
	end
endmodule

// ---- sim/skip_xor_extended_exec_tb_top.sv ----
// Self-checking bench for the skip, xor and extended-set execution block
`timescale 1ns/1ns
`include "sxe_cfg.svh"
module skip_xor_extended_exec_tb_top
	import sxe_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ivalid = 1'b0;
	logic        cfg = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [3:0]  bank_sel = 4'h0;
	logic [7:0]  fdata = 8'h00;
	logic [7:0]  wexp = 8'h00;
	logic [31:0] seed = 32'h0000004B;
	logic        file_rd, indexed_mode, flag_n, flag_z, flag_we, skip_active, quarter_q1;
	logic        ptr_lit, auto_ret, ext_en;
	logic [11:0] file_addr;
	logic [7:0]  working;
	sxe_ext_t    ext_kind;
	logic [9:0]  xq[$];
	logic [12:0] aq[$];
	int          fail_count = 0;
	int          tests_run = 0;
	int          sk_cnt = 0;

	// 100 ns core clock
	always #50 core_clk = ~core_clk;

	sxe_exec DUT (.core_clk(core_clk), .rst(rst), .instr(instr), .instr_valid(ivalid),
		.extended_set_config_bit(cfg), .bank_select_register(bank_sel), .file_data(fdata),
		.file_rd(file_rd), .file_addr(file_addr), .indexed_mode(indexed_mode),
		.working(working), .flag_n(flag_n), .flag_z(flag_z), .flag_we(flag_we),
		.skip_active(skip_active), .quarter_q1(quarter_q1), .ext_kind_q(ext_kind),
		.ptr_literal_q(ptr_lit), .auto_return_q(auto_ret), .ext_enabled(ext_en));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Xorshift source, fixed start
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// One 4-clock instruction slot, aligned on the Q1 state
	task automatic run(input logic v, input logic [15:0] w, input logic [7:0] d);
		int n;
		n = 0;
		while (quarter_q1 !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		if (n == 8) begin
			fail_count++;
			tally_and_finish();
		end
		ivalid = v;
		instr = w;
		fdata = d;
		repeat (4) @(negedge core_clk);
	endtask

	// Xor slot; a discarded one leaves no note
	task automatic xo(input logic [7:0] k, input logic live);
		if (live) begin
			wexp ^= k;
			xq.push_back({wexp[7], wexp == 8'h00, wexp});
		end
		run(1'b1, {`SXE_OP_XORL_HI, k}, rnd());
	endtask

	// Skip slot, then an xor that is discarded when the skip is taken
	task automatic skp(input logic a, input logic [7:0] f, input logic [7:0] d);
		logic idx;
		idx = !a && cfg && f <= 8'h5F;
		aq.push_back({idx, idx ? {4'h0, f} : a ? {bank_sel, f} : {{4{f[7]}}, f}});
		sk_cnt = 0;
		run(1'b1, {`SXE_OP_TSTZ_HI, a, f}, d);
		xo(8'h3C, d != 8'h00);
		run(1'b0, 16'h0000, 8'h00);
		chk("skip_cycles", (d == 8'h00) ? 16'h0004 : 16'h0000, sk_cnt[15:0]);
	endtask

	task automatic ext(input logic [15:0] w, input sxe_ext_t k, input logic p, input logic r);
		run(1'b1, w, 8'h00);
		chk("ext_kind", k, ext_kind);
		chk("ptr_literal", p, ptr_lit);
		chk("auto_return", r, auto_ret);
	endtask

	// Output watcher: each result takes the oldest note
	always @(negedge core_clk) begin
		if (skip_active === 1'b1) sk_cnt++;
		if (flag_we === 1'b1) begin
			if (xq.size() == 0) chk("flag_we", 16'h0000, 16'h0001);
			else chk("xor_result", xq.pop_front(), {flag_n, flag_z, working});
		end
		if (file_rd === 1'b1) begin
			if (aq.size() == 0) chk("file_rd", 16'h0000, 16'h0001);
			else chk("file_addr", aq.pop_front(), {indexed_mode, file_addr});
		end
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(negedge core_clk);
		chk("ext_enabled", 16'h0000, ext_en);
		rst = 1'b0;
		// Back-to-back xors, one forced to a zero result
		for (int i = 0; i < 12; i++) xo(i == 5 ? wexp : rnd(), 1'b1);
		$display("Test xor done");
		bank_sel = 4'hA;
		skp(1'b0, 8'h12, 8'h00);
		skp(1'b0, 8'h90, 8'h55);
		skp(1'b1, 8'h34, 8'h00);
		skp(1'b1, 8'hF0, 8'h01);
		ext(16'hE8C5, SXE_EXT_NONE, 1'b0, 1'b0);
		$display("Test skip done");
		cfg = 1'b1;
		run(1'b0, 16'h0000, 8'h00);
		chk("ext_enabled", 16'h0001, ext_en);
		ext(16'hE805, SXE_EXT_ADDP, 1'b1, 1'b0);
		ext(16'hE8C5, SXE_EXT_ADDR, 1'b1, 1'b1);
		ext(16'hE945, SXE_EXT_SUBP, 1'b1, 1'b0);
		ext(16'hE9C5, SXE_EXT_SUBR, 1'b1, 1'b1);
		ext(16'hEA33, SXE_EXT_PUSHL, 1'b1, 1'b0);
		ext(16'hEB12, SXE_EXT_MVSF, 1'b0, 1'b0);
		ext(16'hEB92, SXE_EXT_MVSS, 1'b0, 1'b0);
		ext(`SXE_OP_CALL_VIA_WORKING_REGISTER, SXE_EXT_CALL_VIA_WORKING_REGISTER, 1'b0, 1'b0);
		// Indexed boundary at 5Fh and 60h just above it
		skp(1'b0, 8'h5F, 8'h00);
		skp(1'b0, 8'h60, 8'h07);
		skp(1'b1, 8'h20, 8'h00);
		skp(1'b0, 8'h00, 8'h80);
		$display("Test extended done");
		run(1'b0, 16'h0000, 8'h00);
		chk("pending_notes", 16'h0000, 16'(xq.size() + aq.size()));
		tally_and_finish();
	end
endmodule
